// File: logic/cdp_gpr_file.sv
/*
  General register file: one write port, two registered read ports.
  Assumes writes come only from the write-back stage; a same-slot write is bypassed.
*/
`timescale 1ns/1ps
`include "cdp_params.svh"

module cdp_gpr_file
  import cdp_pkg::*;
(
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst_b,
  // Write port
  input wire logic wrEn,
  input wire cdp_reg_t wrAddr,
  input wire logic [`CDP_DW-1:0] wrData,
  // Read ports
  input wire cdp_reg_t rdAddrA,
  input wire cdp_reg_t rdAddrB,
  output logic [`CDP_DW-1:0] rdDataA,
  output logic [`CDP_DW-1:0] rdDataB
);

  logic [`CDP_DW-1:0] mem [`CDP_NREG];

  always_ff @(posedge core_clk)
  begin
    if (wrEn)
    begin
      mem[wrAddr] <= wrData;
    end
  end

  // Read data come out of registers; a write in the same slot wins
  always_ff @(posedge core_clk)
  begin
    if (!rst_b)
    begin
      rdDataA <= `CDP_ZERO_WORD;
      rdDataB <= `CDP_ZERO_WORD;
    end
    else
    begin
      rdDataA <= (wrEn && wrAddr == rdAddrA) ? wrData : mem[rdAddrA];
      rdDataB <= (wrEn && wrAddr == rdAddrB) ? wrData : mem[rdAddrB];
    end
  end

endmodule

// File: logic/cdp_hazard_unit.sv
/*
  Hazard unit: load-use interlock, MAC-transfer contention and memory-path claim.
  Assumes the sequencer holds decode and inserts a bubble into execute on stall.
*/
`timescale 1ns/1ps

module cdp_hazard_unit
  import cdp_pkg::*;
(
  // Clock and reset, for the checks only
  input wire logic core_clk,
  input wire logic rst_b,
  // Stage records and verdicts
  cdp_hz_if.hazard hz
);

  logic readsExDst;

  // ---------------------------------------------------------------------------
  // Load-use interlock
  // ---------------------------------------------------------------------------
  assign readsExDst = (hz.idStage.useA && (hz.idStage.srcA == hz.exStage.dst)) ||
                      (hz.idStage.useB && (hz.idStage.srcB == hz.exStage.dst));
  assign hz.loadUse = hz.idStage.valid && hz.exStage.valid &&
                      (hz.exStage.cls == CDP_LOAD) && readsExDst;

  // ---------------------------------------------------------------------------
  // MAC register transfers against DSP memory moves
  // ---------------------------------------------------------------------------
  assign hz.macContend = hz.idStage.valid && hz.exStage.valid &&
    (((hz.idStage.cls == CDP_DSP_MAC_XFER) && (hz.exStage.cls == CDP_DSP_MEM_MOVE)) ||
     ((hz.idStage.cls == CDP_DSP_MEM_MOVE) && (hz.exStage.cls == CDP_DSP_MAC_XFER)));

  // Extra slots arise only from contention with a following instruction
  assign hz.stall = hz.loadUse || hz.macContend;

  // Execute moving into memory access claims the path for the next slot
  assign hz.memClaim = hz.exStage.valid && cdp_uses_mem(hz.exStage.cls);

  // ---------------------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------------------
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_b);

  AST_LOAD_USE_STALL: assert property (
    (hz.exStage.valid && hz.exStage.cls == CDP_LOAD && hz.idStage.valid &&
     hz.idStage.useA && hz.idStage.srcA == hz.exStage.dst) |-> hz.stall)
    else $error("load-use hazard did not stall");

  AST_MAC_CONTEND: assert property (
    (hz.idStage.valid && hz.exStage.valid && hz.idStage.cls == CDP_DSP_MAC_XFER &&
     hz.exStage.cls == CDP_DSP_MEM_MOVE) |-> hz.stall)
    else $error("mac transfer against memory move did not stall");

  AST_NO_SPURIOUS_STALL: assert property (
    (hz.exStage.valid && hz.exStage.cls == CDP_REG_XFER) |-> !hz.stall)
    else $error("stall without contention");

endmodule

// File: logic/cdp_hz_if.sv
/*
  Carrier between the sequencer and its hazard unit: stage records and verdicts.
  Assumes both ends run on the same core clock.
*/
`timescale 1ns/1ps

interface cdp_hz_if;
  import cdp_pkg::*;
  cdp_stage_s idStage;
  cdp_stage_s exStage;
  logic stall;
  logic loadUse;
  logic macContend;
  logic memClaim;

  modport ctrl (output idStage, output exStage,
                input stall, input loadUse, input macContend, input memClaim);
  modport hazard (input idStage, input exStage,
                  output stall, output loadUse, output macContend, output memClaim);
endinterface

// File: logic/cdp_params.svh
/*
  Named constants for the CPU/DSP pipeline sequencer: widths and stage timing.
  Assumes it is included by bare name from the package and the design modules.
*/
`ifndef CDP_PARAMS_SVH
`define CDP_PARAMS_SVH

// -----------------------------------------------------------------------------
// Widths
// -----------------------------------------------------------------------------
`define CDP_DW 32
`define CDP_RAW 4
`define CDP_NREG 16

// -----------------------------------------------------------------------------
// Stage timing, counted in slots from the decode slot
// -----------------------------------------------------------------------------
`define CDP_ID_TO_MA 2
`define CDP_ID_TO_WB 3

// -----------------------------------------------------------------------------
// Reset values
// -----------------------------------------------------------------------------
`define CDP_ZERO_WORD 32'h0000_0000
`define CDP_ZERO_REG 4'h0

`endif

// File: logic/cdp_pipeline_ctrl.sv
/*
  Five-stage pipeline sequencer for the CPU with DSP extension: fetch slot
  issue, decode/execute/memory-access/write-back records, general register
  write-back, load-use interlock and fetch versus memory-access arbitration.
  Assumes a zero-wait fetch bus that answers in the slot it is granted, a
  zero-wait data bus, and an external ALU that returns its result in execute.
*/
`timescale 1ns/1ps
`include "cdp_params.svh"

module cdp_pipeline_ctrl
  import cdp_pkg::*;
(
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst_b,
  // Fetch bus
  input wire logic fetchEnable,
  output logic fetchReq,
  input wire logic instrValid,
  input wire cdp_class_e instrCls,
  input wire cdp_reg_t instrDst,
  input wire cdp_reg_t instrSrcA,
  input wire cdp_reg_t instrSrcB,
  input wire logic instrUseA,
  input wire logic instrUseB,
  // Execute operands and result
  output logic [`CDP_DW-1:0] exSrcA,
  output logic [`CDP_DW-1:0] exSrcB,
  input wire logic [`CDP_DW-1:0] exResult,
  // Data memory bus
  output logic memReq,
  output logic memWrite,
  output logic [`CDP_DW-1:0] memAddr,
  output logic [`CDP_DW-1:0] memWdata,
  input wire logic [`CDP_DW-1:0] memRdata,
  // Status and write-back
  output logic stallActive,
  output logic wbEn,
  output cdp_reg_t wbReg,
  output logic [`CDP_DW-1:0] wbData,
  output logic dspDone
);

  cdp_hz_if hz ();

  cdp_stage_s inStage;
  cdp_stage_s skid_q;
  logic skidValid_q;
  logic skidValid_d;
  cdp_stage_s id_q;
  cdp_stage_s ex_q;
  cdp_stage_s ma_q;
  logic [`CDP_DW-1:0] maData_q;
  logic fetchReq_q;
  logic memReq_q;
  logic memWrite_q;
  logic [`CDP_DW-1:0] memAddr_q;
  logic [`CDP_DW-1:0] memWdata_q;
  logic stallActive_q;
  logic wbEn_q;
  cdp_reg_t wbReg_q;
  logic [`CDP_DW-1:0] wbData_q;
  logic dspDone_q;
  logic advance;
  logic incoming;

  // ---------------------------------------------------------------------------
  // Submodules
  // ---------------------------------------------------------------------------
  cdp_hazard_unit u_hazard (
    .core_clk (core_clk),
    .rst_b (rst_b),
    .hz (hz.hazard)
  );

  cdp_gpr_file u_gpr (
    .core_clk (core_clk),
    .rst_b (rst_b),
    .wrEn (wbEn_q),
    .wrAddr (wbReg_q),
    .wrData (wbData_q),
    .rdAddrA (id_q.srcA),
    .rdAddrB (id_q.srcB),
    .rdDataA (exSrcA),
    .rdDataB (exSrcB)
  );

  assign hz.idStage = id_q;
  assign hz.exStage = ex_q;

  // ---------------------------------------------------------------------------
  // Fetch slot and skid entry
  // ---------------------------------------------------------------------------
  assign inStage = '{valid: 1'b1, cls: instrCls, dst: instrDst, srcA: instrSrcA,
                     srcB: instrSrcB, useA: instrUseA, useB: instrUseB};
  assign advance = !hz.stall;
  assign incoming = fetchReq_q && instrValid;

  // The skid holds the one fetch already granted when decode stalls
  always_comb
  begin
    if (advance)
    begin
      skidValid_d = skidValid_q && incoming;
    end
    else
    begin
      skidValid_d = skidValid_q || incoming;
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (!rst_b)
    begin
      skidValid_q <= 1'b0;
      skid_q <= CDP_BUBBLE;
    end
    else
    begin
      skidValid_q <= skidValid_d;
      if (incoming && (skidValid_q || !advance))
      begin
        skid_q <= inStage;
      end
    end
  end

  // Next fetch one slot later unless memory access or a full skid holds it
  always_ff @(posedge core_clk)
  begin
    if (!rst_b)
    begin
      fetchReq_q <= 1'b0;
    end
    else
    begin
      fetchReq_q <= fetchEnable && !hz.memClaim && !skidValid_d;
    end
  end

  // ---------------------------------------------------------------------------
  // Decode and execute records
  // ---------------------------------------------------------------------------
  always_ff @(posedge core_clk)
  begin
    if (!rst_b)
    begin
      id_q <= CDP_BUBBLE;
    end
    else if (advance)
    begin
      id_q <= skidValid_q ? skid_q : (incoming ? inStage : CDP_BUBBLE);
    end
  end

  // A stall holds decode and sends a bubble into execute
  always_ff @(posedge core_clk)
  begin
    if (!rst_b)
    begin
      ex_q <= CDP_BUBBLE;
    end
    else
    begin
      ex_q <= advance ? id_q : CDP_BUBBLE;
    end
  end

  // ---------------------------------------------------------------------------
  // Memory-access stage
  // ---------------------------------------------------------------------------
  always_ff @(posedge core_clk)
  begin
    if (!rst_b)
    begin
      ma_q <= CDP_BUBBLE;
      maData_q <= `CDP_ZERO_WORD;
    end
    else
    begin
      ma_q <= ex_q;
      maData_q <= exResult;
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (!rst_b)
    begin
      memReq_q <= 1'b0;
      memWrite_q <= 1'b0;
      memAddr_q <= `CDP_ZERO_WORD;
      memWdata_q <= `CDP_ZERO_WORD;
    end
    else
    begin
      memReq_q <= hz.memClaim;
      memWrite_q <= ex_q.valid &&
                    ((ex_q.cls == CDP_STORE) || (ex_q.cls == CDP_STORE_PREDEC));
      memAddr_q <= exResult;
      memWdata_q <= exSrcA;
    end
  end

  // ---------------------------------------------------------------------------
  // Write-back stage
  // ---------------------------------------------------------------------------
  always_ff @(posedge core_clk)
  begin
    if (!rst_b)
    begin
      wbEn_q <= 1'b0;
      wbReg_q <= `CDP_ZERO_REG;
      wbData_q <= `CDP_ZERO_WORD;
    end
    else
    begin
      wbEn_q <= ma_q.valid && cdp_writes_gpr(ma_q.cls);
      wbReg_q <= ma_q.dst;
      wbData_q <= (ma_q.cls == CDP_LOAD) ? memRdata : maData_q;
    end
  end

  // DSP results complete in their fifth stage
  always_ff @(posedge core_clk)
  begin
    if (!rst_b)
    begin
      dspDone_q <= 1'b0;
    end
    else
    begin
      dspDone_q <= ma_q.valid && ((ma_q.cls == CDP_DSP_OP) ||
                   (ma_q.cls == CDP_DSP_MAC_XFER));
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (!rst_b)
    begin
      stallActive_q <= 1'b0;
    end
    else
    begin
      stallActive_q <= hz.stall;
    end
  end

  assign fetchReq = fetchReq_q;
  assign memReq = memReq_q;
  assign memWrite = memWrite_q;
  assign memAddr = memAddr_q;
  assign memWdata = memWdata_q;
  assign stallActive = stallActive_q;
  assign wbEn = wbEn_q;
  assign wbReg = wbReg_q;
  assign wbData = wbData_q;
  assign dspDone = dspDone_q;

  // ---------------------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------------------
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_b);

  AST_FETCH_YIELDS: assert property (memReq_q |-> !fetchReq_q)
    else $error("fetch granted while memory access holds the path");

  AST_REG_XFER_WB: assert property (
    (id_q.valid && id_q.cls == CDP_REG_XFER && advance) |->
    ##2 (ma_q.cls == CDP_REG_XFER && !memReq_q) ##1
    (wbEn_q && wbReg_q == $past(id_q.dst, 3)))
    else $error("register transfer not written in write-back slot");

  AST_PREDEC_WB: assert property (
    (id_q.valid && id_q.cls == CDP_STORE_PREDEC && advance) |->
    ##2 (memReq_q && memWrite_q) ##1 (wbEn_q && wbReg_q == $past(id_q.dst, 3)))
    else $error("pre-decrement store base not written back");

  AST_STORE_NO_WB: assert property (
    (ma_q.valid && ma_q.cls == CDP_STORE) |=> !wbEn_q)
    else $error("store produced a write-back");

  AST_LOAD_MEM_SLOT: assert property (
    (id_q.valid && id_q.cls == CDP_LOAD && advance) |->
    ##2 (memReq_q && !memWrite_q) ##1 wbEn_q)
    else $error("load missed its memory-access or write-back slot");

  AST_DSP_FIVE_STAGES: assert property (
    (id_q.valid && id_q.cls == CDP_DSP_OP && advance) |-> ##3 dspDone_q)
    else $error("dsp operation did not finish in its fifth stage");

  AST_STALL_BUBBLE: assert property (
    hz.stall |=> (!ex_q.valid && $stable(id_q)))
    else $error("stall did not hold decode and insert a bubble");

  AST_BACK_TO_BACK: assert property (
    (incoming && !skidValid_q && advance) |=> (id_q.valid && id_q.dst == $past(instrDst)))
    else $error("fetched instruction did not enter decode next slot");

  COV_LOAD_USE: cover property (hz.loadUse ##1 !hz.stall);
  COV_MAC_CONTEND: cover property (hz.macContend);
  COV_PREDEC: cover property (ma_q.valid && ma_q.cls == CDP_STORE_PREDEC ##1 wbEn_q);
  COV_SKID: cover property (skidValid_q && advance);

endmodule

// File: logic/cdp_pkg.sv
/*
  Types shared by the pipeline sequencer: instruction classes and stage record.
  Assumes the constant header is on the include path.
*/
`include "cdp_params.svh"

package cdp_pkg;

  // ---------------------------------------------------------------------------
  // Instruction classes, one-hot
  // ---------------------------------------------------------------------------
  typedef enum logic [7:0] {
    CDP_NONE         = 8'h01,
    CDP_REG_XFER     = 8'h02,
    CDP_LOAD         = 8'h04,
    CDP_STORE        = 8'h08,
    CDP_STORE_PREDEC = 8'h10,
    CDP_DSP_OP       = 8'h20,
    CDP_DSP_MAC_XFER = 8'h40,
    CDP_DSP_MEM_MOVE = 8'h80
  } cdp_class_e;

  typedef logic [`CDP_RAW-1:0] cdp_reg_t;

  typedef struct packed {
    logic valid;
    cdp_class_e cls;
    cdp_reg_t dst;
    cdp_reg_t srcA;
    cdp_reg_t srcB;
    logic useA;
    logic useB;
  } cdp_stage_s;

  localparam cdp_stage_s CDP_BUBBLE = '{valid: 1'b0, cls: CDP_NONE, default: '0};

  // Classes whose memory-access stage takes the shared memory path
  function automatic logic cdp_uses_mem(cdp_class_e c);
    cdp_uses_mem = (c == CDP_LOAD) || (c == CDP_STORE) || (c == CDP_STORE_PREDEC) ||
                   (c == CDP_DSP_MEM_MOVE);
  endfunction

  // Classes that write a general register in the write-back stage
  function automatic logic cdp_writes_gpr(cdp_class_e c);
    cdp_writes_gpr = (c == CDP_REG_XFER) || (c == CDP_LOAD) || (c == CDP_STORE_PREDEC);
  endfunction

endpackage

// File: verif/cdp_bus_model.sv
/*
  Far side of the sequencer: fetch bus fed from a program table, zero-wait data memory.
  Assumes the bench fills prog and nProg; answers change at the falling edge.
*/
`timescale 1ns/1ps
`include "cdp_params.svh"

module cdp_bus_model
  import cdp_pkg::*;
(
  // Clock
  input wire logic core_clk,
  // Fetch bus
  input wire logic fetchReq,
  output logic instrValid,
  output cdp_class_e instrCls,
  output cdp_reg_t instrDst,
  output cdp_reg_t instrSrcA,
  output cdp_reg_t instrSrcB,
  output logic instrUseA,
  output logic instrUseB,
  // Data bus
  input wire logic memReq,
  input wire logic [`CDP_DW-1:0] memAddr,
  output logic [`CDP_DW-1:0] memRdata
);
  cdp_stage_s prog [1024];
  cdp_stage_s cur = CDP_BUBBLE;
  int nProg = 0;
  int idx = 0;

  function automatic logic [31:0] rd_word(logic [31:0] a);
    rd_word = {a[15:0], a[31:16]} ^ 32'h5A3C_96E1;
  endfunction

  assign instrCls = cur.cls;
  assign instrDst = cur.dst;
  assign instrSrcA = cur.srcA;
  assign instrSrcB = cur.srcB;
  assign instrUseA = cur.useA;
  assign instrUseB = cur.useB;

  initial
  begin
    instrValid = 1'b0;
    memRdata = 32'h0000_0000;
  end

  // Unselected lines except instrValid show the inverse of their last value; instrValid drops low
  always @(negedge core_clk)
  begin
    if (fetchReq && idx < nProg)
      cur = prog[idx];
    else
      cur = cdp_stage_s'(~cur);
    instrValid = fetchReq && idx < nProg && cur.valid;
    memRdata = memReq ? rd_word(memAddr) : ~memRdata;
  end

  // A bubble entry still consumes its fetch slot
  always @(posedge core_clk)
    if (fetchReq && idx < nProg)
      idx <= idx + 1;
endmodule

// File: verif/tb_cpu_dsp_pipeline_timing.sv
/*
  Self-checking bench: fixed-latency stage model per fetched instruction.
  Assumes the bus model answers fetch and data requests with zero wait.
*/
`timescale 1ns/1ps

module tb_cpu_dsp_pipeline_timing
  import cdp_pkg::*;
;
  logic core_clk = 1'b0;
  logic rst_b = 1'b0;
  logic fetchEnable = 1'b1;
  logic feRand = 1'b0;
  logic [31:0] exResult = 32'h0000_0000;
  logic fetchReq, instrValid, instrUseA, instrUseB, memReq, memWrite;
  logic stallActive, wbEn, dspDone;
  cdp_class_e instrCls;
  cdp_reg_t instrDst, instrSrcA, instrSrcB, wbReg;
  logic [31:0] exSrcA, exSrcB, memAddr, memWdata, memRdata, wbData;
  cdp_stage_s lg [1024];
  int fc [1024];
  int pen [1024];
  int xc [1024];
  int id1 = 0;
  logic pad = 1'b1;
  logic [31:0] wd [1024];
  logic [31:0] exLog [4096];
  logic [31:0] gprM [16];
  cdp_class_e clsTab [7] = '{CDP_REG_XFER, CDP_LOAD, CDP_STORE, CDP_STORE_PREDEC,
    CDP_DSP_OP, CDP_DSP_MAC_XFER, CDP_DSP_MEM_MOVE};
  int cyc = 0;
  int nLog = 0;
  int fails = 0;
  int n_compared = 0;

  cdp_pipeline_ctrl uut (.core_clk(core_clk), .rst_b(rst_b), .fetchEnable(fetchEnable),
    .fetchReq(fetchReq), .instrValid(instrValid), .instrCls(instrCls), .instrDst(instrDst),
    .instrSrcA(instrSrcA), .instrSrcB(instrSrcB), .instrUseA(instrUseA),
    .instrUseB(instrUseB), .exSrcA(exSrcA), .exSrcB(exSrcB), .exResult(exResult),
    .memReq(memReq), .memWrite(memWrite), .memAddr(memAddr), .memWdata(memWdata),
    .memRdata(memRdata), .stallActive(stallActive), .wbEn(wbEn), .wbReg(wbReg),
    .wbData(wbData), .dspDone(dspDone));

  cdp_bus_model mdl (.core_clk(core_clk), .fetchReq(fetchReq), .instrValid(instrValid),
    .instrCls(instrCls), .instrDst(instrDst), .instrSrcA(instrSrcA), .instrSrcB(instrSrcB),
    .instrUseA(instrUseA), .instrUseB(instrUseB), .memReq(memReq), .memAddr(memAddr),
    .memRdata(memRdata));

  initial
    forever #2.5 core_clk = ~core_clk;

  // --------
  // Expectations
  // --------
  function automatic logic [31:0] exp_rd(logic [31:0] a);
    exp_rd = {a[15:0], a[31:16]} ^ 32'h5A3C_96E1;
  endfunction

  // Adjacent pairs that cost one stall
  function automatic bit hazard(cdp_stage_s a, cdp_stage_s b);
    hazard = (a.cls == CDP_LOAD && ((b.useA && b.srcA == a.dst) || (b.useB && b.srcB == a.dst)))
      || (a.cls == CDP_DSP_MAC_XFER && b.cls == CDP_DSP_MEM_MOVE)
      || (a.cls == CDP_DSP_MEM_MOVE && b.cls == CDP_DSP_MAC_XFER);
  endfunction

  task automatic chk_bit(string nm, logic e, logic s);
    n_compared++;
    if (s !== e)
    begin
      fails++;
      $display("mismatch %s expected %0h seen %0h", nm, e, s);
    end
  endtask

  task automatic chk_reg(string nm, cdp_reg_t e, cdp_reg_t s);
    n_compared++;
    if (s !== e)
    begin
      fails++;
      $display("mismatch %s expected %0h seen %0h", nm, e, s);
    end
  endtask

  task automatic chk_word(string nm, logic [31:0] e, logic [31:0] s);
    n_compared++;
    if (s !== e)
    begin
      fails++;
      $display("mismatch %s expected %0h seen %0h", nm, e, s);
    end
  endtask

  task automatic check_cycle();
    logic eMem, eWr, eSt, eWb, eDsp, eStl;
    logic [31:0] eAddr, eWd, eWbd;
    cdp_reg_t eReg;
    cdp_stage_s s;
    int e;
    {eMem, eWr, eSt, eWb, eDsp, eStl} = 6'h00;
    for (int j = (nLog > 8) ? nLog - 8 : 0; j < nLog; j++)
    begin
      s = lg[j];
      e = xc[j];
      if (e - 1 == cyc)
        wd[j] = gprM[s.srcA];
      if (pen[j] == 1 && e - 1 == cyc)
        eStl = 1'b1;
      if (e + 1 == cyc && s.cls inside {CDP_LOAD, CDP_STORE, CDP_STORE_PREDEC, CDP_DSP_MEM_MOVE})
      begin
        eMem = 1'b1;
        eWr = s.cls inside {CDP_STORE, CDP_STORE_PREDEC};
        eSt = eWr;
        eAddr = exLog[e % 4096];
        eWd = wd[j];
      end
      if (e + 2 == cyc && s.cls inside {CDP_REG_XFER, CDP_LOAD, CDP_STORE_PREDEC})
      begin
        eWb = 1'b1;
        eReg = s.dst;
        eWbd = (s.cls == CDP_LOAD) ? exp_rd(exLog[e % 4096]) : exLog[e % 4096];
        gprM[s.dst] = eWbd;
      end
      if (e + 2 == cyc && s.cls inside {CDP_DSP_OP, CDP_DSP_MAC_XFER})
        eDsp = 1'b1;
    end
    chk_bit("memReq", eMem, memReq);
    chk_bit("fetchReq", 1'b0, fetchReq & memReq);
    chk_bit("wbEn", eWb, wbEn);
    chk_bit("dspDone", eDsp, dspDone);
    chk_bit("stallActive", eStl, stallActive);
    if (eMem)
      chk_bit("memWrite", eWr, memWrite);
    if (eMem)
      chk_word("memAddr", eAddr, memAddr);
    if (eSt)
      chk_word("memWdata", eWd, memWdata);
    if (eWb)
      chk_reg("wbReg", eReg, wbReg);
    if (eWb)
      chk_word("wbData", eWbd, wbData);
  endtask

  // --------
  // Monitor and drive
  // --------
  always @(posedge core_clk)
  begin
    if (rst_b && fetchReq && instrValid && nLog < 1024)
    begin
      lg[nLog] = '{1'b1, instrCls, instrDst, instrSrcA, instrSrcB, instrUseA, instrUseB};
      fc[nLog] = cyc;
      // Decode entry waits until the older instruction leaves decode (skid case)
      id1 = (nLog > 0 && xc[nLog-1] > cyc + 1) ? xc[nLog-1] : cyc + 1;
      pen[nLog] = (nLog > 0 && id1 == xc[nLog-1] && hazard(lg[nLog-1], lg[nLog])) ? 1 : 0;
      xc[nLog] = id1 + 1 + pen[nLog];
      nLog++;
    end
    cyc++;
  end

  always @(negedge core_clk)
  begin
    if (rst_b)
      check_cycle();
    exResult = $urandom;
    exLog[cyc % 4096] = exResult;
    if (feRand)
      fetchEnable = ($urandom_range(7) != 0);
  end

  task automatic put(cdp_class_e c, cdp_reg_t d, cdp_reg_t a, cdp_reg_t b, logic ua, logic ub);
    cdp_stage_s s;
    logic hz;
    s = '{1'b1, c, d, a, b, ua, ub};
    hz = mdl.nProg > 0 && hazard(mdl.prog[mdl.nProg-1], s);
    mdl.prog[mdl.nProg] = s;
    mdl.nProg++;
    for (int i = 0; i < 3 && hz && pad; i++)
      mdl.prog[mdl.nProg++] = CDP_BUBBLE;
  endtask

  task automatic end_of_test();
    $display("compared %0d mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  task automatic run(string nm);
    int k;
    k = 0;
    while (mdl.idx < mdl.nProg && k < 5000)
    begin
      @(negedge core_clk);
      k++;
    end
    repeat (10) @(negedge core_clk);
    if (k >= 5000)
      fails++;
    if (k >= 5000)
      end_of_test();
    $display("test %s done", nm);
  endtask

  // --------
  // Tests
  // --------
  initial
  begin
    void'($urandom(32'hd9814cfd));
    for (int i = 0; i < 16; i++)
      put(CDP_REG_XFER, cdp_reg_t'(i), 4'h0, 4'h0, 1'b0, 1'b0);
    repeat (20) @(negedge core_clk);
    rst_b = 1'b1;
    run("init");
    for (int i = 1; i < 16; i++)
      chk_bit("fetchSlot", 1'b1, fc[i] == fc[0] + i);
    put(CDP_LOAD, 4'h5, 4'h1, 4'h2, 1'b1, 1'b0);
    put(CDP_REG_XFER, 4'h6, 4'h5, 4'h0, 1'b1, 1'b0);
    put(CDP_LOAD, 4'h9, 4'h1, 4'h2, 1'b1, 1'b0);
    put(CDP_STORE, 4'h4, 4'h3, 4'h9, 1'b1, 1'b1);
    put(CDP_DSP_MEM_MOVE, 4'h0, 4'h0, 4'h0, 1'b0, 1'b0);
    put(CDP_DSP_MAC_XFER, 4'h0, 4'h0, 4'h0, 1'b0, 1'b0);
    put(CDP_DSP_MAC_XFER, 4'h0, 4'h0, 4'h0, 1'b0, 1'b0);
    put(CDP_DSP_MEM_MOVE, 4'h0, 4'h0, 4'h0, 1'b0, 1'b0);
    put(CDP_STORE, 4'h4, 4'h6, 4'h0, 1'b1, 1'b0);
    put(CDP_STORE, 4'h4, 4'h6, 4'h0, 1'b1, 1'b0);
    put(CDP_STORE_PREDEC, 4'h2, 4'h7, 4'h2, 1'b1, 1'b1);
    put(CDP_DSP_OP, 4'h0, 4'h0, 4'h0, 1'b0, 1'b0);
    run("corners");
    pad = 1'b0;
    put(CDP_LOAD, 4'h8, 4'h1, 4'h0, 1'b1, 1'b0);
    put(CDP_REG_XFER, 4'hA, 4'h8, 4'h0, 1'b1, 1'b0);
    put(CDP_STORE, 4'h3, 4'hA, 4'h0, 1'b1, 1'b0);
    run("skid");
    feRand = 1'b1;
    for (int i = 0; i < 300; i++)
      put(clsTab[$urandom_range(6)], cdp_reg_t'($urandom), cdp_reg_t'($urandom),
        cdp_reg_t'($urandom), 1'($urandom), 1'($urandom));
    run("random");
    end_of_test();
  end
endmodule
